// ---- logic/adc_overrange_detector.v ----
// Purpose: per-channel over-range detection on converted samples, with AXI4-Lite control
// Assumes: samples arrive already synchronous to mclk_in, one per clock per channel
// Notes:   enable, threshold and pulse-length setting are all shared across channels
`include "overrange_map.vh"

module adc_overrange_detector #(
	parameter CHANNELS = 4
)(
	input  wire        mclk_in,
	input  wire        sys_rst_in,
	input  wire [11:0] sample_a_in,
	input  wire [11:0] sample_b_in,
	input  wire [11:0] sample_c_in,
	input  wire [11:0] sample_d_in,
	output wire        overrange_out_a,
	output wire        overrange_out_b,
	output wire        overrange_out_c,
	output wire        overrange_out_d,
	output wire [7:0]  full_scale_setting_out,
	output wire        irq_out,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ------------------------------------------------------------------------
	// reset values of the control fields, cut out of the packed reset word
	// ------------------------------------------------------------------------
	localparam [15:0] CTRL_RESET_VALUE = `CTRL_RESET;
	localparam [0:0]  ENABLE_RESET     = CTRL_RESET_VALUE[`CTRL_ENABLE_BIT];
	localparam [2:0]  SEL_RESET        = CTRL_RESET_VALUE[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
	localparam [7:0]  FS_RESET         = CTRL_RESET_VALUE[`CTRL_FS_MSB:`CTRL_FS_LSB];

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	reg        overrange_detect_enable_reg;
	reg [2:0]  overrange_pulse_length_sel_reg;
	reg [7:0]  full_scale_setting_reg;
	reg [7:0]  overrange_threshold_reg;
	reg [3:0]  status_reg;
	reg [3:0]  mask_reg;
	reg [3:0]  awaddr_reg;
	reg        aw_held_reg;
	reg [31:0] wdata_reg;
	reg [3:0]  wstrb_reg;
	reg        w_held_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0]  rresp_reg;
	wire [47:0] samples_all;
	wire [3:0]  hit;
	wire [3:0]  pulse;
	wire        do_write;
	wire        status_clear;
	reg  [10:0] pulse_len;

	assign samples_all = {sample_d_in, sample_c_in, sample_b_in, sample_a_in};

	// pulse length decode: base of 8 shifted by the setting
	// 8 shifted by 7 gives 1024, which still fits the eleven-bit counter
	always @*
	begin
		pulse_len = `PULSE_BASE_CYCLES << overrange_pulse_length_sel_reg;
	end

	// ------------------------------------------------------------------------
	// per-channel detection
	// ------------------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1)
		begin : g_chan
			wire [11:0] code;
			wire [10:0] mag;
			reg  [10:0] count_reg;
			reg         out_reg;
			assign code = samples_all[ch*12 +: 12];
			// saturate the -2048 case instead of letting the negation wrap
			// the negation then only sees -2047..-1, whose magnitude fits eleven bits
			assign mag = (code == 12'h800) ? 11'h7FF :
				(code[11] ? 11'h000 - code[10:0] : code[10:0]);
			// spare channels of smaller variants never flag
			assign hit[ch] = (ch < CHANNELS) && overrange_detect_enable_reg &&
				(mag[10:3] >= overrange_threshold_reg);
			// registered once per clock so the output is one cycle behind the sample
			always @(posedge mclk_in)
			begin
				if (sys_rst_in || !overrange_detect_enable_reg)
				begin
					count_reg <= 11'h000;
					out_reg   <= 1'b0;
				end
				else if (hit[ch])
				begin
					// the reload edge is itself the first high cycle, hence length minus one
					count_reg <= pulse_len - 11'h001;
					out_reg   <= 1'b1;
				end
				else if (count_reg != 11'h000)
				begin
					count_reg <= count_reg - 11'h001;
					out_reg   <= 1'b1;
				end
				else
				begin
					out_reg <= 1'b0;
				end
			end
			assign pulse[ch] = out_reg;
		end
	endgenerate

	// channels map to outputs in alphabetical order
	assign overrange_out_a = pulse[0];
	assign overrange_out_b = pulse[1];
	assign overrange_out_c = pulse[2];
	assign overrange_out_d = pulse[3];
	assign full_scale_setting_out = full_scale_setting_reg;

	// ------------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------------
	// bvalid blocks both readies so a second write cannot overtake an unanswered one
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign status_clear  = do_write && (awaddr_reg == `OVR_STATUS_OFFSET) && wstrb_reg[0];

	// address and data latch independently, write commits once both are in
	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `AXI_RESP_OKAY;
			awaddr_reg  <= 4'h0;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
			overrange_detect_enable_reg    <= ENABLE_RESET;
			overrange_pulse_length_sel_reg <= SEL_RESET;
			full_scale_setting_reg         <= FS_RESET;
			overrange_threshold_reg        <= `THRESH_RESET;
			mask_reg    <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= `AXI_RESP_OKAY;
				case (awaddr_reg)
					`OVR_CTRL_OFFSET:
					begin
						if (wstrb_reg[0])
						begin
							overrange_detect_enable_reg    <= wdata_reg[`CTRL_ENABLE_BIT];
							overrange_pulse_length_sel_reg <=
								wdata_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
						end
						if (wstrb_reg[1])
							full_scale_setting_reg <= wdata_reg[`CTRL_FS_MSB:`CTRL_FS_LSB];
					end
					`OVR_THRESH_OFFSET:
					begin
						if (wstrb_reg[0])
							overrange_threshold_reg <= wdata_reg[7:0];
					end
					`OVR_STATUS_OFFSET:
					begin
						// the write-one clear itself is done in the status process
						bresp_reg <= `AXI_RESP_OKAY;
					end
					`OVR_MASK_OFFSET:
					begin
						if (wstrb_reg[0])
							mask_reg <= wdata_reg[3:0];
					end
					default:
					begin
						bresp_reg <= `AXI_RESP_SLVERR;
					end
				endcase
			end
			else if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// interrupt status: a new hit wins over a same-cycle write-one clear
	// ------------------------------------------------------------------------
	// spare channels never set status because their hit bits are forced low
	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
			status_reg <= 4'h0;
		else if (status_clear)
			status_reg <= (status_reg & ~wdata_reg[3:0]) | hit;
		else
			status_reg <= status_reg | hit;
	end

	// level output: stays high until software clears or masks the bit
	assign irq_out = |(status_reg & mask_reg);

	// ------------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------------
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// one read at a time; data registered so rdata is steady while rvalid is high
	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= `AXI_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= `AXI_RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'b00})
				`OVR_CTRL_OFFSET:
					rdata_reg <= {16'h0000, full_scale_setting_reg, 1'b0,
						overrange_pulse_length_sel_reg, 3'h0, overrange_detect_enable_reg};
				`OVR_THRESH_OFFSET:
					rdata_reg <= {24'h000000, overrange_threshold_reg};
				`OVR_STATUS_OFFSET:
					rdata_reg <= {24'h000000, pulse, status_reg};
				`OVR_MASK_OFFSET:
					rdata_reg <= {28'h0000000, mask_reg};
				// unreachable with word-aligned offsets, kept so a stray address still answers
				default:
				begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= `AXI_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule // adc_overrange_detector

// ---- logic/overrange_map.vh ----
// Purpose: offsets, field positions, reset values and timing counts for the over-range detector
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes:   definitions only
`ifndef OVERRANGE_MAP_VH
`define OVERRANGE_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OVR_CTRL_OFFSET      4'h0
`define OVR_THRESH_OFFSET    4'h4
`define OVR_STATUS_OFFSET    4'h8
`define OVR_MASK_OFFSET      4'hC

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT      0
`define CTRL_SEL_LSB         4
`define CTRL_SEL_MSB         6
`define CTRL_FS_LSB          8
`define CTRL_FS_MSB          15

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define THRESH_RESET         8'hE4
`define CTRL_RESET           16'h0000
`define PULSE_BASE_CYCLES    11'h008
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// ---- testbench/ovr_calc.svh ----
// Purpose: expected upper magnitude bits of one sample
// Assumes: 12-bit two's complement codes
// Notes:   definitions only
`ifndef OVR_CALC_SVH
`define OVR_CALC_SVH
function automatic logic [7:0] top8(input logic [11:0] c);
	logic [11:0] m;
	m = c[11] ? 12'h000 - c : c;
	return (c == 12'h800) ? 8'hFF : m[10:3];
endfunction
`endif

// ---- testbench/gain_control_model.sv ----
// Purpose: downstream gain control reacting to over-range pulses
// Assumes: pulses are synchronous to the detector clock
// Notes:   gain comes back after 17 quiet cycles so short gaps do not chatter
module gain_control_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] ovr_in,
	output logic            gain_cut_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] quiet_reg;
	// cut gain on any pulse, restore once samples stay clear
	always @(posedge clk_in)
		if (rst_in || ovr_in != 4'h0)
			{quiet_reg, gain_cut_out} <= {5'h00, !rst_in};
		else if (quiet_reg != 5'h10)
			quiet_reg <= quiet_reg + 5'h01;
		else
			gain_cut_out <= 1'b0;
endmodule // gain_control_model

// ---- testbench/overrange_properties.sv ----
// Purpose: port checks of the over-range detector
// Assumes: write address and data are offered together
// Notes:   rise, window and off checks pause 7 cycles after a write, covering the commit delay
`include "ovr_calc.svh"
`include "overrange_map.vh"
module overrange_properties #(
	parameter CHANNELS = 4
)(
	input wire logic        mclk_in,
	input wire logic        sys_rst_in,
	input wire logic [11:0] sample_a_in,
	input wire logic        overrange_out_a,
	input wire logic        overrange_out_b,
	input wire logic        overrange_out_c,
	input wire logic        overrange_out_d,
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid
);
	logic [6:0]  ctl_reg;
	logic [7:0]  thr_reg;
	logic [2:0]  age_reg;
	logic [10:0] since_reg;
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire hit_a = ctl_reg[0] && top8(sample_a_in) >= thr_reg;
	wire [10:0] len = 11'h008 << ctl_reg[6:4];
	// shadow of control, threshold, settle age and cycles since the last hit
	always @(posedge mclk_in)
		age_reg <= (sys_rst_in || wr_go) ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
	always @(posedge mclk_in)
		if (sys_rst_in)
			{ctl_reg, thr_reg} <= {7'h00, `THRESH_RESET};
		else if (wr_go && s_axi_awaddr == `OVR_CTRL_OFFSET)
			ctl_reg <= s_axi_wdata[6:0];
		else if (wr_go && s_axi_awaddr == `OVR_THRESH_OFFSET)
			thr_reg <= s_axi_wdata[7:0];
	always @(posedge mclk_in)
		if (sys_rst_in || wr_go || !ctl_reg[0])
			since_reg <= 11'h000;
		else if (hit_a || (since_reg != 11'h000 && since_reg != 11'h7FF))
			since_reg <= hit_a ? 11'h001 : since_reg + 11'h001;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_hold8; overrange_out_a [*8]; endsequence
	property p_wr_resp; wr_go |-> ##[1:2] s_axi_bvalid; endproperty
	property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_rise; $rose(overrange_out_a) && age_reg == 3'h7 |-> $past(hit_a); endproperty
	property p_hold; $rose(overrange_out_a) && ctl_reg[0] |-> s_hold8; endproperty
	property p_window; age_reg == 3'h7 && ctl_reg[0]
		|-> overrange_out_a == (since_reg != 11'h000 && since_reg <= len); endproperty
	property p_off; age_reg == 3'h7 && !ctl_reg[0] |-> !(overrange_out_a
		|| overrange_out_b || overrange_out_c || overrange_out_d); endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
	a_b_busy: assert property (p_b_busy) else $error("write taken while answering");
	a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
	a_r_busy: assert property (p_r_busy) else $error("read taken while answering");
	a_rise: assert property (p_rise) else $error("pulse without hit");
	a_hold: assert property (p_hold) else $error("pulse under 8 cycles");
	a_window: assert property (p_window) else $error("pulse length wrong");
	a_off: assert property (p_off) else $error("pulse while disabled");
endmodule // overrange_properties
bind adc_overrange_detector overrange_properties #(.CHANNELS(CHANNELS)) chk (.*);

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench of the over-range detector
// Assumes: writes offer address and data together
// Notes:   the pulse sweep runs every length up to 1024 cycles
`include "ovr_calc.svh"
`include "overrange_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
	logic        bready = 1'b0, rready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, seen = 4'h0;
	logic [31:0] wdata = 32'h0, rd;
	logic [11:0] smp [4] = '{default: 12'h000};
	logic [11:0] code;
	logic [7:0]  th;
	logic [19:0] corner [6] = '{20'h800FF, 20'h7F0FF, 20'h810FE, 20'h720E4, 20'h8E8E4, 20'h00001};
	int          n_errors = 0, checks = 0, hi;
	wire  [3:0]  ov;
	wire  [7:0]  fs;
	wire  [31:0] rdata;
	wire         irq, gain_cut, awready, wready, bvalid, arready, rvalid;
	adc_overrange_detector #(.CHANNELS(4)) uut (.mclk_in(clk), .sys_rst_in(rst),
		.sample_a_in(smp[0]), .sample_b_in(smp[1]), .sample_c_in(smp[2]), .sample_d_in(smp[3]),
		.overrange_out_a(ov[0]), .overrange_out_b(ov[1]), .overrange_out_c(ov[2]),
		.overrange_out_d(ov[3]), .full_scale_setting_out(fs), .irq_out(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	gain_control_model partner (.clk_in(clk), .rst_in(rst), .ovr_in(ov), .gain_cut_out(gain_cut));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		n_errors += int'(got !== exp);
		if (got !== exp)
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
	endtask
	// one bus transfer; each channel holds until its own ready edge
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t = 0;
		@(posedge clk);
		{awaddr, araddr, wdata} <= {a, a, d};
		{awv, wv, bready, arv, rready} <= {w, w, w, !w, !w};
		do
		begin
			@(posedge clk);
			t++;
			{awv, wv, arv} <= {awv && !awready, wv && !wready, arv && !arready};
			rd = rdata;
		end
		while (!(bvalid || rvalid) && t < 99);
		if (!(bvalid || rvalid))
		begin
			n_errors++;
			$display("MISMATCH %0t bus answer missing", $time);
		end
		{bready, rready} <= 2'b00;
	endtask
	// hold code on one channel for n samples, count how long its pulse stands
	task automatic strike(input int c, input int n);
		hi = 0;
		smp[c] <= code;
		for (int i = 0; i < 1100; i++)
		begin
			@(posedge clk);
			if (i == n - 1)
				smp[c] <= 12'h000;
			#1;
			if (i == 0)
				chk(ov & ~(4'h1 << c), 4'h0);
			if (ov[c])
				hi++;
			else if (hi != 0 || i > n)
				break;
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(32'h1EC4));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		xfer(0, `OVR_THRESH_OFFSET, 0);
		chk(rd, 32'hE4);
		xfer(1, `OVR_CTRL_OFFSET, 32'h1);
		for (int k = 0; k < 30; k++)
		begin
			// a zero threshold would make every idle sample hit, so it is never drawn
			{code, th} = k < 6 ? corner[k] : {12'($urandom), 8'($urandom_range(255, 1))};
			xfer(1, `OVR_THRESH_OFFSET, {24'h0, th});
			hi = $urandom_range(3);
			seen[hi] |= top8(code) >= th;
			strike(hi, 1);
			chk(hi, top8(code) >= th ? 8 : 0);
		end
		chk(irq, 0);
		xfer(1, `OVR_MASK_OFFSET, 32'hF);
		chk(irq, seen != 4'h0);
		xfer(0, `OVR_STATUS_OFFSET, 0);
		chk(rd, {28'h0, seen});
		xfer(1, `OVR_STATUS_OFFSET, {28'h0, seen});
		xfer(0, `OVR_STATUS_OFFSET, 0);
		chk({rd[3:0], irq}, 5'h00);
		code = 12'h7FF;
		// every length setting, restarted by three extra hits
		for (int s = 0; s < 8; s++)
		begin
			th = 8'($urandom);
			xfer(1, `OVR_CTRL_OFFSET, {16'h0, th, 1'b0, 3'(s), 4'h1});
			chk(fs, th);
			strike(s % 4, 4);
			chk({gain_cut, 11'(hi)}, {1'b1, 11'((8 << s) + 3)});
		end
		xfer(1, `OVR_CTRL_OFFSET, 32'h71);
		strike(1, 1);
		chk(hi, 1024);
		xfer(1, `OVR_CTRL_OFFSET, 32'h0);
		strike(2, 1);
		chk(hi, 0);
		chk({28'h0, ov}, 0);
		give_verdict();
	end
endmodule // tb_top
